// File: src/ir_remote_wake_receiver_led_display.sv
// infrared remote wake receiver with two-digit multiplexed hex display
`timescale 1ns/1ps

module ir_remote_wake_receiver_led_display #(
  parameter int SAMPLE_CYCLES = irw_pkg::SAMPLE_CYCLES,
  parameter int SCAN_CYCLES = irw_pkg::SCAN_CYCLES,
  parameter int DEBOUNCE_CYCLES = irw_pkg::DEBOUNCE_CYCLES,
  parameter int OSC_STAB_CYCLES = irw_pkg::OSC_STAB_CYCLES,
  parameter int WAKE_WAIT_STATES = irw_pkg::WAKE_WAIT_STATES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wake_edge_input,
  input wire logic ir_sample_input,
  input wire logic advance_switch_input,
  input wire logic standby_switch_input,
  output logic [7:0] segment_outputs,
  output logic first_digit_select,
  output logic second_digit_select,
  output logic wake_interrupt,
  output logic standby_active
);
  import irw_pkg::*;

  localparam int TW = $clog2(SAMPLE_CYCLES + 1);
  localparam int SW = $clog2(SCAN_CYCLES + 1);
  localparam int DW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam int WW = $clog2(OSC_STAB_CYCLES + WAKE_WAIT_MAX + 1);

  state_t state_reg;
  logic [3:0] s1_reg, s2_reg, s3_reg;
  pins_t pins_reg;
  logic wake_prev_reg;
  logic wake_fall;
  logic [WW-1:0] wake_cnt_reg;
  logic [TW-1:0] tick_cnt_reg;
  logic sample_tick;
  logic ir_smp_reg;
  logic [7:0] space_reg;
  logic armed_reg;
  logic [5:0] bit_cnt_reg;
  logic [31:0] data_reg;
  logic ir_fall;
  logic frame_done;
  logic [1:0] press;
  logic [2:0] byte_idx_reg;
  logic [SW-1:0] scan_cnt_reg;
  logic digit_sel_reg;
  logic [7:0] cur_byte;
  logic [7:0] seg_next;

  // ==========================================================
  // input synchronisers, three stages, change taken when 2 and 3 agree
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_reg <= PINS_IDLE;
      s2_reg <= PINS_IDLE;
      s3_reg <= PINS_IDLE;
      pins_reg <= pins_t'(PINS_IDLE);
    end else begin
      s1_reg <= {standby_switch_input, advance_switch_input,
                 ir_sample_input, wake_edge_input};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < 4; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          pins_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  // ==========================================================
  // switch debounce, pressed is low
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_db
      logic [DW-1:0] cnt_reg;
      logic level_reg;
      logic raw;
      assign raw = g ? pins_reg.standby_sw : pins_reg.advance_sw;
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          cnt_reg <= '0;
          level_reg <= 1'b1;
        end else if (raw == level_reg) begin
          cnt_reg <= '0;
        end else if (cnt_reg == DW'(DEBOUNCE_CYCLES - 1)) begin
          cnt_reg <= '0;
          level_reg <= raw;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
      // one pulse only on the settled release-to-press change
      assign press[g] = (raw == 1'b0) && level_reg &&
                        (cnt_reg == DW'(DEBOUNCE_CYCLES - 1));
    end
  endgenerate

  // ==========================================================
  // power state sequence
  assign wake_fall = wake_prev_reg && !pins_reg.wake;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wake_prev_reg <= 1'b1;
    end else begin
      wake_prev_reg <= pins_reg.wake;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_STANDBY;
      wake_cnt_reg <= '0;
    end else begin
      case (state_reg)
        ST_STANDBY: begin
          wake_cnt_reg <= '0;
          if (wake_fall) begin
            state_reg <= ST_OSC;
          end
        end
        ST_OSC: begin
          if (wake_cnt_reg == WW'(OSC_STAB_CYCLES - 1)) begin
            wake_cnt_reg <= '0;
            state_reg <= ST_WAIT;
          end else begin
            wake_cnt_reg <= wake_cnt_reg + 1'b1;
          end
        end
        ST_WAIT: begin
          if (wake_cnt_reg == WW'(WAKE_WAIT_STATES - 1)) begin
            wake_cnt_reg <= '0;
            state_reg <= ST_RECV;
          end else begin
            wake_cnt_reg <= wake_cnt_reg + 1'b1;
          end
        end
        ST_RECV: begin
          if (frame_done) begin
            state_reg <= ST_DISP;
          end
        end
        ST_DISP: begin
          if (press[1]) begin
            state_reg <= ST_STANDBY;
          end
        end
        default: state_reg <= ST_STANDBY;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wake_interrupt <= 1'b0;
      standby_active <= 1'b1;
    end else begin
      wake_interrupt <= (state_reg == ST_STANDBY) && wake_fall;
      standby_active <= (state_reg == ST_STANDBY);
    end
  end

  // ==========================================================
  // sample tick, runs only while receiving
  assign sample_tick = (state_reg == ST_RECV) &&
                       (tick_cnt_reg == TW'(SAMPLE_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (sys_rst || state_reg != ST_RECV || sample_tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // ==========================================================
  // space measurement and bit assembly; receiver output is low on a mark
  assign ir_fall = sample_tick && ir_smp_reg && !pins_reg.ir;
  assign frame_done = ir_fall && armed_reg &&
                      (space_reg < LEADER_SPACE_MIN_TICKS) &&
                      (bit_cnt_reg == 6'(FRAME_BITS - 1));

  always_ff @(posedge mclk) begin
    if (sys_rst || state_reg != ST_RECV) begin
      ir_smp_reg <= 1'b1;
      space_reg <= '0;
      armed_reg <= 1'b0;
      bit_cnt_reg <= '0;
    end else if (sample_tick) begin
      ir_smp_reg <= pins_reg.ir;
      if (pins_reg.ir) begin
        if (space_reg != SPACE_SAT_TICKS) begin
          space_reg <= space_reg + 1'b1;
        end
        // a stalled frame is dropped, the next leader restarts it
        if (space_reg == SPACE_TIMEOUT_TICKS) begin
          armed_reg <= 1'b0;
          bit_cnt_reg <= '0;
        end
      end else begin
        space_reg <= '0;
        if (ir_fall) begin
          if (space_reg >= LEADER_SPACE_MIN_TICKS) begin
            armed_reg <= 1'b1;
            bit_cnt_reg <= '0;
          end else if (frame_done) begin
            armed_reg <= 1'b0;
          end else if (armed_reg) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end
        end
      end
    end
  end

  // shift in from the top so the first bit lands in bit 0
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_reg <= '0;
    end else if (ir_fall && armed_reg &&
                 space_reg < LEADER_SPACE_MIN_TICKS) begin
      data_reg <= {space_reg >= ONE_SPACE_MIN_TICKS,
                   data_reg[31:1]};
    end
  end

  // ==========================================================
  // byte stepping and digit scan
  always_ff @(posedge mclk) begin
    if (sys_rst || state_reg != ST_DISP) begin
      byte_idx_reg <= '0;
    end else if (press[0] && byte_idx_reg != END_MARK_IDX) begin
      byte_idx_reg <= byte_idx_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || state_reg != ST_DISP) begin
      scan_cnt_reg <= '0;
      digit_sel_reg <= 1'b0;
    end else if (scan_cnt_reg == SW'(SCAN_CYCLES - 1)) begin
      scan_cnt_reg <= '0;
      digit_sel_reg <= !digit_sel_reg;
    end else begin
      scan_cnt_reg <= scan_cnt_reg + 1'b1;
    end
  end

  assign cur_byte = data_reg[{byte_idx_reg[1:0], 3'b000} +: 8];

  always_comb begin
    if (byte_idx_reg == END_MARK_IDX) begin
      seg_next = SEG_DASH;
    end else if (digit_sel_reg) begin
      seg_next = hex_to_seg(cur_byte[7:4]);
    end else begin
      seg_next = hex_to_seg(cur_byte[3:0]);
    end
  end

  // display dark outside of display state to save power
  always_ff @(posedge mclk) begin
    if (sys_rst || state_reg != ST_DISP) begin
      segment_outputs <= SEG_BLANK;
      first_digit_select <= 1'b0;
      second_digit_select <= 1'b0;
    end else begin
      segment_outputs <= seg_next;
      first_digit_select <= !digit_sel_reg;
      second_digit_select <= digit_sel_reg;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic [TW:0] chk_gap_reg;
  logic chk_seen_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst || state_reg != ST_RECV) begin
      chk_gap_reg <= '0;
      chk_seen_reg <= 1'b0;
    end else if (sample_tick) begin
      chk_gap_reg <= '0;
      chk_seen_reg <= 1'b1;
    end else begin
      chk_gap_reg <= chk_gap_reg + 1'b1;
    end
  end

  property p_wake_edge;
    state_reg == ST_STANDBY && wake_fall |=>
      state_reg == ST_OSC && wake_interrupt;
  endproperty
  a_wake_edge: assert property (p_wake_edge)
    else $error("wake edge did not start wake sequence");

  property p_wait_exit;
    $past(state_reg) == ST_WAIT && state_reg == ST_RECV |->
      $past(wake_cnt_reg) == WW'(WAKE_WAIT_STATES - 1);
  endproperty
  a_wait_exit: assert property (p_wait_exit)
    else $error("wait released early or late");

  property p_wait_sixteen;
    WAKE_WAIT_STATES == 16 && $rose(state_reg == ST_WAIT) |->
      ##16 state_reg == ST_RECV;
  endproperty
  a_wait_sixteen: assert property (p_wait_sixteen)
    else $error("wake wait is not sixteen states");

  property p_tick_gap;
    sample_tick && chk_seen_reg |-> chk_gap_reg == (TW+1)'(SAMPLE_CYCLES - 1);
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("sample tick spacing wrong");

  property p_scan_swap;
    state_reg == ST_DISP && $past(state_reg) == ST_DISP &&
      $changed(digit_sel_reg) |->
      $past(scan_cnt_reg) == SW'(SCAN_CYCLES - 1);
  endproperty
  a_scan_swap: assert property (p_scan_swap)
    else $error("digit swapped off the scan overflow");

  property p_one_digit;
    $past(state_reg) == ST_DISP && state_reg == ST_DISP |->
      first_digit_select != second_digit_select;
  endproperty
  a_one_digit: assert property (p_one_digit)
    else $error("digit selects not exclusive");

  property p_low_seg_zero;
    segment_outputs[0] == 1'b0;
  endproperty
  a_low_seg_zero: assert property (p_low_seg_zero)
    else $error("lowest segment line driven");

  property p_nibble_place;
    $past(state_reg) == ST_DISP && state_reg == ST_DISP &&
      $past(byte_idx_reg) != END_MARK_IDX |->
      segment_outputs == hex_to_seg($past(digit_sel_reg) ?
        $past(cur_byte[7:4]) : $past(cur_byte[3:0]));
  endproperty
  a_nibble_place: assert property (p_nibble_place)
    else $error("wrong nibble on digit");

  property p_frame_len;
    frame_done |-> bit_cnt_reg == 6'(FRAME_BITS - 1) ##1 state_reg == ST_DISP;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame closed at wrong bit count");

  property p_advance;
    state_reg == ST_DISP && press[0] && byte_idx_reg != END_MARK_IDX &&
      !press[1] |=> byte_idx_reg == $past(byte_idx_reg) + 3'h1;
  endproperty
  a_advance: assert property (p_advance)
    else $error("advance press did not step byte");

  property p_standby_sw;
    state_reg == ST_DISP && press[1] |=> state_reg == ST_STANDBY;
  endproperty
  a_standby_sw: assert property (p_standby_sw)
    else $error("standby press ignored");

  property p_end_mark;
    $past(state_reg) == ST_DISP && state_reg == ST_DISP &&
      $past(byte_idx_reg) == END_MARK_IDX |-> segment_outputs == SEG_DASH;
  endproperty
  a_end_mark: assert property (p_end_mark)
    else $error("end marker not shown");

  property p_leader;
    ir_fall && space_reg >= LEADER_SPACE_MIN_TICKS |=>
      armed_reg && bit_cnt_reg == 6'h00;
  endproperty
  a_leader: assert property (p_leader)
    else $error("leader did not restart frame");

  property p_single_press;
    press[0] |=> !press[0];
  endproperty
  a_single_press: assert property (p_single_press)
    else $error("press gave two requests");

  c_wake: cover property (state_reg == ST_WAIT ##1 state_reg == ST_RECV);
  c_frame: cover property (frame_done);
  c_dash: cover property (byte_idx_reg == END_MARK_IDX);
  c_back: cover property (state_reg == ST_DISP ##1 state_reg == ST_STANDBY);

endmodule // ir_remote_wake_receiver_led_display

// File: src/irw_pkg.sv
// constants, types and the segment table of the infrared wake receiver
package irw_pkg;

  // ==========================================================
  // clock and times
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_PERIOD_NS = 100_000;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SCAN_PERIOD_NS = 3_276_800;
  localparam int SCAN_CYCLES = SCAN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DEBOUNCE_NS = 20_000_000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_NS / CLK_PERIOD_NS;
  localparam int OSC_STAB_NS = 10_000;
  localparam int OSC_STAB_CYCLES =
    (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // wake wait in states, legal range and chosen setting
  localparam int WAKE_WAIT_MIN = 8;
  localparam int WAKE_WAIT_MAX = 16_384;
  localparam int WAKE_WAIT_STATES = 16;

  // ==========================================================
  // frame layout and space thresholds in sample ticks
  localparam int FRAME_BITS = 32;
  localparam int FRAME_BYTES = 4;
  localparam logic [7:0] ONE_SPACE_MIN_TICKS = 8'h0B;
  localparam logic [7:0] LEADER_SPACE_MIN_TICKS = 8'h1E;
  localparam logic [7:0] SPACE_TIMEOUT_TICKS = 8'h78;
  localparam logic [7:0] SPACE_SAT_TICKS = 8'hFF;
  localparam logic [2:0] END_MARK_IDX = 3'h4;

  // ==========================================================
  // reset values and the end mark pattern
  localparam logic [7:0] SEG_BLANK = 8'h00;
  localparam logic [7:0] SEG_DASH = 8'h02;
  localparam logic [3:0] PINS_IDLE = 4'hF;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_OSC = 3'b001,
    ST_WAIT = 3'b010,
    ST_RECV = 3'b011,
    ST_DISP = 3'b100
  } state_t;

  // filtered pins, all idle high
  typedef struct packed {
    logic standby_sw;
    logic advance_sw;
    logic ir;
    logic wake;
  } pins_t;

  function automatic logic [7:0] hex_to_seg(input logic [3:0] n);
    case (n)
      4'h0: hex_to_seg = 8'hFC;
      4'h1: hex_to_seg = 8'h60;
      4'h2: hex_to_seg = 8'hDA;
      4'h3: hex_to_seg = 8'hF2;
      4'h4: hex_to_seg = 8'h66;
      4'h5: hex_to_seg = 8'hB6;
      4'h6: hex_to_seg = 8'hBE;
      4'h7: hex_to_seg = 8'hE4;
      4'h8: hex_to_seg = 8'hFE;
      4'h9: hex_to_seg = 8'hF6;
      4'hA: hex_to_seg = 8'hEE;
      4'hB: hex_to_seg = 8'h3E;
      4'hC: hex_to_seg = 8'h9C;
      4'hD: hex_to_seg = 8'h7A;
      4'hE: hex_to_seg = 8'h9E;
      default: hex_to_seg = 8'h8E;
    endcase
  endfunction

endpackage

// File: tb/ir_remote_model.sv
// behavioural infrared receiver output sending pulse-position frames
`timescale 1ns/1ps
module ir_remote_model #(
  parameter int TICK = 10
) (
  input wire logic mclk,
  output logic ir_line
);
  // line idles high, as the receiver output does between frames
  initial ir_line = 1'b1;

  // ==========================================================
  // level held for a number of sample ticks
  task automatic hold(input logic lvl, input int n);
    @(posedge mclk);
    ir_line <= lvl;
    repeat (n * TICK - 1) @(posedge mclk);
  endtask

  // ==========================================================
  // whole frame, leader first, then 32 bits lsb first
  task automatic send_frame(input logic [7:0] b0, input logic [7:0] b2,
      input int one_sp, input int zero_sp);
    logic [31:0] f;
    f = {~b2, b2, ~b0, b0};
    hold(1'b0, 20);
    hold(1'b1, 40);
    for (int i = 0; i < 32; i++) begin
      hold(1'b0, 6);
      hold(1'b1, f[i] ? one_sp : zero_sp);
    end
    // trailing mark, else the last space never ends
    hold(1'b0, 6);
    hold(1'b1, 1);
  endtask
endmodule // ir_remote_model

// File: tb/ir_remote_wake_receiver_led_display_tb.sv
// self-checking bench for the infrared wake receiver and display
`timescale 1ns/1ps
module ir_remote_wake_receiver_led_display_tb;
  // short counts keep the run small
  localparam int SAMP = 10;
  localparam int SCAN = 16;
  localparam logic [7:0] SEG_TAB [16] = '{8'hFC, 8'h60, 8'hDA, 8'hF2,
    8'h66, 8'hB6, 8'hBE, 8'hE4, 8'hFE, 8'hF6, 8'hEE, 8'h3E, 8'h9C, 8'h7A,
    8'h9E, 8'h8E};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ir_line;
  logic advance_switch_input = 1'b1;
  logic standby_switch_input = 1'b1;
  logic [7:0] segment_outputs;
  logic first_digit_select;
  logic second_digit_select;
  logic wake_interrupt;
  logic standby_active;
  int num_errors = 0;
  int comparisons = 0;
  int wake_cnt = 0;
  int seed = 32'h1e89;

  always #5 mclk = ~mclk;

  ir_remote_wake_receiver_led_display #(
    .SAMPLE_CYCLES(SAMP),
    .SCAN_CYCLES(SCAN),
    .DEBOUNCE_CYCLES(4),
    .OSC_STAB_CYCLES(8),
    .WAKE_WAIT_STATES(16)
  ) u_ir_remote_wake_receiver_led_display (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wake_edge_input(ir_line),
    .ir_sample_input(ir_line),
    .advance_switch_input(advance_switch_input),
    .standby_switch_input(standby_switch_input),
    .segment_outputs(segment_outputs),
    .first_digit_select(first_digit_select),
    .second_digit_select(second_digit_select),
    .wake_interrupt(wake_interrupt),
    .standby_active(standby_active)
  );

  ir_remote_model #(
    .TICK(SAMP)
  ) u_ir_remote_model (
    .mclk(mclk),
    .ir_line(ir_line)
  );

  // only wake pulses count, and they fire on an edge in standby only, one per frame
  always @(posedge mclk) begin
    if (wake_interrupt === 1'b1)
      wake_cnt++;
  end

  // ==========================================================
  // compare and verdict
  task automatic check(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [7:0] seg_of(input logic [3:0] n);
    return SEG_TAB[n];
  endfunction

  // ==========================================================
  // display and switch helpers
  task automatic wait_sel(input logic [1:0] want, input bit strict,
      output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
      // both lit or both dark must trip, so compare the xor every edge
      if (strict)
        check("one select", 16'(second_digit_select ^ first_digit_select),
          16'h0001);
    end while ({second_digit_select, first_digit_select} !== want &&
      n < 200);
  endtask

  task automatic show(input logic [7:0] lo, input logic [7:0] hi);
    int n;
    wait_sel(2'b10, 1'b0, n);
    wait_sel(2'b01, 1'b1, n);
    check("low digit", 16'(segment_outputs), 16'(lo));
    wait_sel(2'b10, 1'b1, n);
    check("high digit", 16'(segment_outputs), 16'(hi));
    check("scan period", n[15:0], 16'(SCAN));
  endtask

  task automatic press(input bit stby);
    @(posedge mclk);
    if (stby)
      standby_switch_input <= 1'b0;
    else
      advance_switch_input <= 1'b0;
    repeat (20) @(posedge mclk);
    standby_switch_input <= 1'b1;
    advance_switch_input <= 1'b1;
    repeat (20) @(posedge mclk);
  endtask

  task automatic wait_wake();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (wake_interrupt !== 1'b1 && n < 100);
    check("wake pulse", 16'(wake_interrupt), 16'h0001);
    @(posedge mclk);
    #1;
    check("wake width", 16'(wake_interrupt), 16'h0000);
    // standby flag follows the state register, one edge after the pulse
    check("standby left", 16'(standby_active), 16'h0000);
  endtask

  // ==========================================================
  // one frame from wake to standby
  task automatic run_frame(input logic [7:0] b0, input logic [7:0] b2,
      input int one_sp, input int zero_sp);
    logic [7:0] bytes [4];
    bytes = '{b0, ~b0, b2, ~b2};
    fork
      u_ir_remote_model.send_frame(b0, b2, one_sp, zero_sp);
      wait_wake();
    join
    for (int i = 0; i < 4; i++) begin
      show(seg_of(bytes[i][3:0]), seg_of(bytes[i][7:4]));
      press(1'b0);
    end
    show(8'h02, 8'h02);
    press(1'b0);
    show(8'h02, 8'h02);
    press(1'b1);
    #1;
    check("standby", 16'(standby_active), 16'h0001);
    check("blank", 16'(segment_outputs), 16'h0000);
    check("selects off", 16'(first_digit_select), 16'h0000);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    check("reset segments", 16'(segment_outputs), 16'h0000);
    check("reset standby", 16'(standby_active), 16'h0001);
    check("reset select", 16'(second_digit_select), 16'h0000);
    run_frame(8'h50, 8'h17, 17, 6);
    // spaces at the one threshold and one tick below it
    run_frame(8'($random(seed)), 8'($random(seed)), 11, 10);
    // longest one space, a tick short of what restarts as a leader
    run_frame(8'($random(seed)), 8'($random(seed)), 29, 6);
    check("wake count", wake_cnt[15:0], 16'h0003);
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    end_sim();
  end
endmodule // ir_remote_wake_receiver_led_display_tb
